// >>> logic/psc_top.sv
// start-source control for four pulse generator channels, Avalon-MM slave
`timescale 1ns/1ps
`include "psc_consts.svh"

// Behaviour
// - both selects 0: software start bit only
// - software bit 1 starts output, holds on
// - software bit 0 stops channel output
// - gate select 1, timing select 0: external timer gate
// - output follows gate asserted, stops negated
// - negated gate means no further output
// - timing select 1: timing generator start
// - counter-go write 1 starts up-counter
// - count equals match value: start asserted
// - stop bit written 0 negates start
// - clock select divides by 2,8,32,64
// - counter stops itself at 0xFF
// - match value zero disables compare
// - stop write beats simultaneous match
module psc_top
   import psc_pkg::*;
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic [`PSC_AW-1:0] address_in,
   input wire logic read_in,
   input wire logic write_in,
   input wire logic [`PSC_DW-1:0] writedata_in,
   input wire logic [3:0] byteenable_in,
   input wire logic [`PSC_NCH-1:0] gate_in,
   output logic [`PSC_DW-1:0] readdata_out,
   output logic waitrequest_out,
   output logic [`PSC_NCH-1:0] pulse_run_out
);

   psc_top_s q;
   psc_top_s d;

   psc_tg_if tg_bus ();

   psc_timing_gen u_tgen (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .tg(tg_bus)
   );

   function automatic logic [`PSC_DW-1:0] psc_merge(
      input logic [`PSC_DW-1:0] old_v,
      input logic [`PSC_DW-1:0] new_v,
      input logic [3:0] be
   );
      logic [`PSC_DW-1:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      psc_merge = r;
   endfunction : psc_merge

   function automatic logic [`PSC_DW-1:0] psc_read(
      input logic [`PSC_AW-1:0] addr,
      input psc_top_s s,
      input logic running,
      input logic [7:0] count,
      input logic [`PSC_NCH-1:0] start
   );
      logic [`PSC_DW-1:0] r;
      r = '0;
      case (addr)
         `PSC_OFS_TGCTRL: begin
            r[`PSC_TG_RUN_BIT] = running;
            r[`PSC_TG_CSEL_HI:`PSC_TG_CSEL_LO] = s.csel;
            r[`PSC_TG_STOP_HI:`PSC_TG_STOP_LO] = '1;
         end
         `PSC_OFS_COMPARE: r = s.cmp;
         `PSC_OFS_SWSTART: r[`PSC_NCH-1:0] = s.sw_start;
         `PSC_OFS_MODE: begin
            r[`PSC_MODE_TTS_HI:`PSC_MODE_TTS_LO] = s.tts;
            r[`PSC_MODE_GSS_HI:`PSC_MODE_GSS_LO] = s.gss;
         end
         `PSC_OFS_STATUS: begin
            r[`PSC_ST_RUN_HI:`PSC_ST_RUN_LO] = s.run;
            r[`PSC_ST_START_HI:`PSC_ST_START_LO] = start;
            r[`PSC_ST_CNT_HI:`PSC_ST_CNT_LO] = count;
         end
         default: r = '0;
      endcase
      psc_read = r;
   endfunction : psc_read

   always_comb begin
      d = q;
      d.go = 1'b0;
      d.stop = '0;
      d.gate_m = gate_in;
      d.gate_s = q.gate_m;
      case (q.bus)
         PSC_BUS_IDLE: begin
            if (read_in || write_in) begin
               d.bus = PSC_BUS_DONE;
               d.waitreq = 1'b0;
               d.rdata = read_in ?
                  psc_read(address_in, q, tg_bus.running, tg_bus.count, tg_bus.start) : '0;
            end
         end
         PSC_BUS_DONE: begin
            d.bus = PSC_BUS_IDLE;
            d.waitreq = 1'b1;
            if (write_in && byteenable_in[0]) begin
               case (address_in)
                  `PSC_OFS_TGCTRL: begin
                     d.go = writedata_in[`PSC_TG_GO_BIT];
                     d.csel = writedata_in[`PSC_TG_CSEL_HI:`PSC_TG_CSEL_LO];
                     d.stop = ~writedata_in[`PSC_TG_STOP_HI:`PSC_TG_STOP_LO];
                  end
                  `PSC_OFS_SWSTART: d.sw_start = writedata_in[`PSC_NCH-1:0];
                  `PSC_OFS_MODE: begin
                     d.tts = writedata_in[`PSC_MODE_TTS_HI:`PSC_MODE_TTS_LO];
                     d.gss = writedata_in[`PSC_MODE_GSS_HI:`PSC_MODE_GSS_LO];
                  end
                  default: d.go = 1'b0;
               endcase
            end
            if (write_in && (address_in == `PSC_OFS_COMPARE)) begin
               d.cmp = psc_merge(q.cmp, writedata_in, byteenable_in);
            end
         end
         default: begin
            d.bus = PSC_BUS_IDLE;
            d.waitreq = 1'b1;
         end
      endcase
      for (int i = 0; i < `PSC_NCH; i++) begin
         if (q.tts[i]) begin
            d.run[i] = tg_bus.start[i];
         end else if (q.gss[i]) begin
            d.run[i] = q.gate_s[i];
         end else begin
            d.run[i] = q.sw_start[i];
         end
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         q <= '0;
         q.bus <= PSC_BUS_IDLE;
         q.waitreq <= 1'b1;
         q.csel <= `PSC_CSEL_RESET;
         q.cmp <= `PSC_CMP_RESET;
      end else begin
         q <= d;
      end
   end

   assign tg_bus.go = q.go;
   assign tg_bus.stop = q.stop;
   assign tg_bus.csel = q.csel;
   assign tg_bus.cmp = q.cmp;

   assign readdata_out = q.rdata;
   assign waitrequest_out = q.waitreq;
   assign pulse_run_out = q.run;

endmodule : psc_top

// >>> logic/psc_consts.svh
// named constants for the pulse generator start-source control block
`ifndef PSC_CONSTS_SVH
`define PSC_CONSTS_SVH

`define PSC_NCH 4
`define PSC_AW 5
`define PSC_DW 32

// register byte addresses
`define PSC_OFS_TGCTRL 5'h00
`define PSC_OFS_COMPARE 5'h04
`define PSC_OFS_SWSTART 5'h08
`define PSC_OFS_MODE 5'h0c
`define PSC_OFS_STATUS 5'h10

// timing generator control fields
`define PSC_TG_GO_BIT 0
`define PSC_TG_RUN_BIT 1
`define PSC_TG_CSEL_LO 2
`define PSC_TG_CSEL_HI 3
`define PSC_TG_STOP_LO 4
`define PSC_TG_STOP_HI 7

// mode register fields
`define PSC_MODE_TTS_LO 0
`define PSC_MODE_TTS_HI 3
`define PSC_MODE_GSS_LO 4
`define PSC_MODE_GSS_HI 7

// status register fields
`define PSC_ST_RUN_LO 0
`define PSC_ST_RUN_HI 3
`define PSC_ST_START_LO 4
`define PSC_ST_START_HI 7
`define PSC_ST_CNT_LO 8
`define PSC_ST_CNT_HI 15

// counter clock select codes and divider terminal counts
`define PSC_CSEL_DIV2 2'h0
`define PSC_CSEL_DIV8 2'h1
`define PSC_CSEL_DIV32 2'h2
`define PSC_CSEL_DIV64 2'h3
`define PSC_CSEL_RESET 2'h0
`define PSC_DIV2_LAST 6'h01
`define PSC_DIV8_LAST 6'h07
`define PSC_DIV32_LAST 6'h1f
`define PSC_DIV64_LAST 6'h3f

// up-counter limits
`define PSC_CNT_ZERO 8'h00
`define PSC_CNT_MAX 8'hff
`define PSC_CNT_STEP 8'h01
`define PSC_DIV_STEP 6'h01
`define PSC_CMP_OFF 8'h00
`define PSC_CMP_RESET 32'h0000_0000

`endif

// >>> logic/psc_pkg.sv
// types shared by the start-source control modules
`include "psc_consts.svh"

package psc_pkg;

   typedef enum logic [0:0] {
      PSC_BUS_IDLE = 1'b0,
      PSC_BUS_DONE = 1'b1
   } psc_bus_e;

   typedef logic [`PSC_NCH-1:0][7:0] psc_cmp_t;

   typedef struct packed {
      psc_bus_e bus;
      logic waitreq;
      logic [`PSC_DW-1:0] rdata;
      logic [`PSC_NCH-1:0] sw_start;
      logic [`PSC_NCH-1:0] tts;
      logic [`PSC_NCH-1:0] gss;
      logic [1:0] csel;
      psc_cmp_t cmp;
      logic go;
      logic [`PSC_NCH-1:0] stop;
      logic [`PSC_NCH-1:0] gate_m;
      logic [`PSC_NCH-1:0] gate_s;
      logic [`PSC_NCH-1:0] run;
   } psc_top_s;

   typedef struct packed {
      logic [5:0] div;
      logic [7:0] count;
      logic running;
      logic step;
      logic [`PSC_NCH-1:0] start;
   } psc_tg_s;

endpackage : psc_pkg

// >>> logic/psc_tg_if.sv
// link between the register side and the timing generator
`timescale 1ns/1ps
`include "psc_consts.svh"

interface psc_tg_if;
   import psc_pkg::*;
   logic go;
   logic [`PSC_NCH-1:0] stop;
   logic [1:0] csel;
   psc_cmp_t cmp;
   logic running;
   logic [7:0] count;
   logic [`PSC_NCH-1:0] start;

   modport ctrl (output go, output stop, output csel, output cmp,
                 input running, input count, input start);
   modport tgen (input go, input stop, input csel, input cmp,
                 output running, output count, output start);
endinterface : psc_tg_if

// >>> logic/psc_timing_gen.sv
// timing generator: prescaler, 8-bit up-counter and per-channel compare
`timescale 1ns/1ps
`include "psc_consts.svh"

module psc_timing_gen
   import psc_pkg::*;
(
   input wire logic clk_in,
   input wire logic nrst_in,
   psc_tg_if.tgen tg
);

   psc_tg_s q;
   psc_tg_s d;

   function automatic logic [5:0] psc_div_last(input logic [1:0] sel);
      case (sel)
         `PSC_CSEL_DIV2: psc_div_last = `PSC_DIV2_LAST;
         `PSC_CSEL_DIV8: psc_div_last = `PSC_DIV8_LAST;
         `PSC_CSEL_DIV32: psc_div_last = `PSC_DIV32_LAST;
         `PSC_CSEL_DIV64: psc_div_last = `PSC_DIV64_LAST;
         default: psc_div_last = `PSC_DIV2_LAST;
      endcase
   endfunction : psc_div_last

   always_comb begin
      logic hit;
      hit = 1'b0;
      d = q;
      d.step = 1'b0;
      if (tg.go) begin
         // every start restarts from zero
         d.count = `PSC_CNT_ZERO;
         d.div = '0;
         d.running = 1'b1;
      end else if (q.running) begin
         if (q.div >= psc_div_last(tg.csel)) begin
            d.div = '0;
            d.count = q.count + `PSC_CNT_STEP;
            d.step = 1'b1;
            if (q.count == (`PSC_CNT_MAX - `PSC_CNT_STEP)) begin
               d.running = 1'b0;
            end
         end else begin
            d.div = q.div + `PSC_DIV_STEP;
         end
      end
      for (int i = 0; i < `PSC_NCH; i++) begin
         // compare only on the cycle the count has just moved
         hit = q.step && (q.count == tg.cmp[i]) && (tg.cmp[i] != `PSC_CMP_OFF);
         // a stop written in the same cycle as a match wins
         d.start[i] = (q.start[i] | hit) & ~tg.stop[i];
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tg.running = q.running;
   assign tg.count = q.count;
   assign tg.start = q.start;

endmodule : psc_timing_gen

// >>> bench/psc_top_chk.sv
// port checker for the start-source control block
`timescale 1ns/1ps
module psc_top_chk (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic [4:0] address_in,
   input wire logic read_in,
   input wire logic write_in,
   input wire logic [31:0] writedata_in,
   input wire logic [3:0] byteenable_in,
   input wire logic [3:0] gate_in,
   input wire logic [31:0] readdata_out,
   input wire logic waitrequest_out,
   input wire logic [3:0] pulse_run_out
);
   logic [3:0] tts_q, gss_q, sw_q, g1_q, g2_q;
   wire wd = write_in && !waitrequest_out && byteenable_in[0];
   wire [3:0] swm = ~tts_q & ~gss_q;
   wire [3:0] gm = ~tts_q & gss_q;
   wire [3:0] stp = (wd && address_in == 5'h00) ? ~writedata_in[7:4] & tts_q : 4'h0;
   // shadow of mode, software bits and gate sync
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         {tts_q, gss_q, sw_q, g1_q, g2_q} <= 20'h0;
      end else begin
         g1_q <= gate_in;
         g2_q <= g1_q;
         if (wd && address_in == 5'h0c) {gss_q, tts_q} <= writedata_in[7:0];
         if (wd && address_in == 5'h08) sw_q <= writedata_in[3:0];
      end
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   property p_sw; ((pulse_run_out ^ $past(sw_q)) & $past(swm)) == 4'h0; endproperty
   a_sw: assert property (p_sw) else $error("sw out");
   property p_sw_on; wd && address_in == 5'h08 && writedata_in[0] && swm[0]
      |-> ##2 pulse_run_out[0]; endproperty
   a_sw_on: assert property (p_sw_on) else $error("sw start");
   property p_gate; ((pulse_run_out ^ $past(g2_q)) & $past(gm)) == 4'h0; endproperty
   a_gate: assert property (p_gate) else $error("gate out");
   property p_gate_off; (gm[1] && !gate_in[1]) [*4] |-> !pulse_run_out[1]; endproperty
   a_gate_off: assert property (p_gate_off) else $error("gate off");
   property p_stop; stp != 4'h0 |-> ##3 (pulse_run_out & $past(stp, 3)) == 4'h0;
   endproperty
   a_stop: assert property (p_stop) else $error("stop bit");
   property p_wait; !waitrequest_out |=> waitrequest_out; endproperty
   a_wait: assert property (p_wait) else $error("wait long");
   property p_ack; (read_in || write_in) && waitrequest_out |=> !waitrequest_out; endproperty
   a_ack: assert property (p_ack) else $error("no answer");
   property p_unmap; read_in && waitrequest_out && (address_in > 5'h10
      || address_in[1:0] != 2'h0) |=> readdata_out == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped");
   c_stop: cover property (stp != 4'h0);
   c_gate: cover property ((pulse_run_out & gm) != 4'h0);
   c_go: cover property (wd && address_in == 5'h00 && writedata_in[0]);
endmodule : psc_top_chk
bind psc_top psc_top_chk psc_top_chk_i (.clk_in(clk_in), .nrst_in(nrst_in),
   .address_in(address_in), .read_in(read_in), .write_in(write_in),
   .writedata_in(writedata_in), .byteenable_in(byteenable_in), .gate_in(gate_in),
   .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
   .pulse_run_out(pulse_run_out));

// >>> bench/psc_gate_src.sv
// model of the external waveform timer gate outputs
`timescale 1ns/1ps
module psc_gate_src (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic [3:0] run_in,
   input wire logic [3:0] level_in,
   output logic [3:0] gate_out
);
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         gate_out <= 4'h0;
      end else begin
         gate_out <= run_in & level_in;
      end
   end
endmodule : psc_gate_src

// >>> bench/test_pulse_gen_start_source_ctrl.sv
// self-checking bench for the start-source control block
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module test_pulse_gen_start_source_ctrl;
   logic clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic [4:0] address_in = 5'h00;
   logic read_in = 1'b0;
   logic write_in = 1'b0;
   logic [31:0] writedata_in = 32'h0;
   logic [3:0] byteenable_in = 4'hf;
   logic [3:0] g_run = 4'h0;
   logic [3:0] g_lvl = 4'h0;
   logic [3:0] gate_in, pulse_run_out;
   logic [31:0] readdata_out, rd;
   logic waitrequest_out;
   int err_count = 0;
   int comparisons = 0;
   int cyc = 0;
   psc_top psc_top_i (.clk_in(clk_in), .nrst_in(nrst_in),
      .address_in(address_in), .read_in(read_in), .write_in(write_in),
      .writedata_in(writedata_in), .byteenable_in(byteenable_in), .gate_in(gate_in),
      .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
      .pulse_run_out(pulse_run_out));
   psc_gate_src psc_gate_src_i (.clk_in(clk_in), .nrst_in(nrst_in), .run_in(g_run),
      .level_in(g_lvl), .gate_out(gate_in));
   always #25 clk_in = ~clk_in;
   task bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge clk_in);
      address_in <= a;
      writedata_in <= d;
      byteenable_in <= be;
      write_in <= w;
      read_in <= !w;
      // waitrequest low ends this wait; if it never drops, only the bench timeout does
      do begin
         @(posedge clk_in);
      end while (waitrequest_out !== 1'b0);
      rd = readdata_out;
      write_in <= 1'b0;
      read_in <= 1'b0;
   endtask : bus
   task wr(input logic [4:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hf);
   endtask : wr
   task rdchk(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 4'hf);
      `CHK(rd, e)
   endtask : rdchk
   task t_reset;
      rdchk(5'h00, 32'hf0);
      rdchk(5'h04, 32'h0);
      rdchk(5'h10, 32'h0);
   endtask : t_reset
   task t_sw;
      wr(5'h08, 32'h5);
      repeat (2) @(posedge clk_in);
      `CHK(pulse_run_out, 4'h5)
      wr(5'h14, 32'hf);
      rdchk(5'h02, 32'h0);
      `CHK(pulse_run_out, 4'h5)
      wr(5'h08, 32'h1);
      repeat (2) @(posedge clk_in);
      `CHK(pulse_run_out, 4'h1)
   endtask : t_sw
   task t_gate;
      wr(5'h0c, 32'hf0);
      g_run <= 4'hf;
      g_lvl <= 4'ha;
      repeat (6) @(posedge clk_in);
      `CHK(pulse_run_out, 4'ha)
      g_lvl <= 4'h5;
      repeat (6) @(posedge clk_in);
      `CHK(pulse_run_out, 4'h5)
      g_run <= 4'h0;
      repeat (6) @(posedge clk_in);
      `CHK(pulse_run_out, 4'h0)
   endtask : t_gate
   task t_tg;
      wr(5'h0c, 32'hff);
      wr(5'h08, 32'hf);
      g_run <= 4'hf;
      g_lvl <= 4'hf;
      rdchk(5'h00, 32'hf0);
      bus(1'b1, 5'h04, 32'hff402010, 4'h7);
      rdchk(5'h04, 32'h00402010);
      wr(5'h00, 32'hf1);
      repeat (50) @(posedge clk_in);
      `CHK(pulse_run_out, 4'h1)
      repeat (50) @(posedge clk_in);
      `CHK(pulse_run_out, 4'h3)
      repeat (500) @(posedge clk_in);
      rdchk(5'h10, 32'h0000ff77);
      wr(5'h00, 32'he0);
      repeat (4) @(posedge clk_in);
      `CHK(pulse_run_out, 4'h6)
      g_run <= 4'h0;
   endtask : t_tg
   task t_race;
      wr(5'h00, 32'hf1);
      // the channel 0 stop lands in the very cycle of its 0x10 match
      repeat (30) @(posedge clk_in);
      wr(5'h00, 32'he0);
      repeat (40) begin
         @(posedge clk_in);
         `CHK(pulse_run_out[0], 1'b0)
      end
      do begin
         bus(1'b0, 5'h00, 32'h0, 4'hf);
      end while (rd[1] !== 1'b0);
   endtask : t_race
   task t_csel;
      int n;
      int per_step;
      for (int c = 0; c < 4; c++) begin
         // divide ratios 2, 8, 32, 64: ten counter steps per wait
         per_step = (c == 3) ? 64 : (2 << (2 * c));
         wr(5'h00, 32'hf1 | 32'(c) << 2);
         repeat (10 * per_step) @(posedge clk_in);
         bus(1'b0, 5'h10, 32'h0, 4'hf);
         `CHK(rd[15:8] inside {[8'h09:8'h0b]}, 1'b1)
         rdchk(5'h00, 32'hf2 | 32'(c) << 2);
         n = 0;
         do begin
            bus(1'b0, 5'h00, 32'h0, 4'hf);
            n++;
         end while (rd[1] !== 1'b0 && n < 9000);
         `CHK(rd[15:0], 16'h00f0 | 16'(c) << 2)
      end
   endtask : t_csel
   task give_verdict;
      $display("err_count %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 60000) begin
         err_count++;
         give_verdict();
      end
   end
   initial begin
      repeat (10) @(posedge clk_in);
      nrst_in <= 1'b1;
      t_reset();
      t_sw();
      t_gate();
      t_tg();
      t_race();
      t_csel();
      give_verdict();
   end
endmodule : test_pulse_gen_start_source_ctrl
